// >>> bench/acp_host_model.sv
// Host controller model that selects the port, clocks frames and sends commands.
`timescale 1ns/1ps
module acp_host_model (
    input wire logic sdo_i,
    input wire logic sck_i,
    output logic cs_b_o,
    output logic sck_o,
    output logic sdi_o
);
    initial
    begin
        cs_b_o = 1'b1;
        sck_o = 1'b0;
        sdi_o = 1'b0;
    end

    task automatic select(input logic level);
        cs_b_o = level;
    endtask : select

    // The host clock stands still outside frames; idle input bits toggle.
    task automatic frame(input logic [12:0] cmd, input int n, input bit own_clk,
                         output logic [31:0] data);
        int k;
        data = 32'h0;
        for (k = 0; k < 400 && sdo_i !== 1'b0; k++) #97;
        sdi_o = cmd[12];
        for (k = 0; k < n; k++)
        begin
            if (own_clk)
            begin
                @(posedge sck_i);
                data = {data[30:0], sdo_i};
                @(negedge sck_i);
            end
            else
            begin
                sck_o = 1'b1;
                #390;
                data = {data[30:0], sdo_i};
                #10;
                sck_o = 1'b0;
            end
            sdi_o = (k < 12) ? cmd[11-k] : ~sdi_o;
            if (!own_clk) #400;
        end
    endtask : frame
endmodule : acp_host_model

// >>> bench/acp_serial_port_bench.sv
// Self-checking bench for the converter serial port.
`timescale 1ns/1ps
module acp_serial_port_bench
    import acp_pkg::*;
;
    logic clk_sys_i, rst_b_i, clk_src_strap_i, conv_done_i, conv_over_i, conv_under_i;
    logic [RESULT_W-1:0] conv_value_i;
    logic cs_b, host_sck, sdi, sck_pin, sdo_pin, sdo_hold;
    logic sck_o, sck_oe_b_o, sdo_o, sdo_oe_b_o, conv_start_o, mode_2x_o, conv_busy_o;
    logic [CHAN_W-1:0] chan_addr_o;
    logic [SPD_W-1:0] speed_code_o;
    logic [31:0] got;
    int n_fail = 0;
    int comparisons = 0;
    int n_pulse = 0;

    // A released data line shows the inverse of its last level, never a kind guess.
    assign sck_pin = sck_oe_b_o ? host_sck : sck_o;
    assign sdo_pin = sdo_oe_b_o ? ~sdo_hold : sdo_o;
    always_ff @(posedge clk_sys_i) if (!sdo_oe_b_o) sdo_hold <= sdo_o;
    always @(posedge sck_pin) if (sck_oe_b_o === 1'b0) n_pulse++;

    acp_serial_port dut (
        .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .clk_src_strap_i(clk_src_strap_i),
        .cs_b_i(cs_b), .sck_i(sck_pin), .sck_o(sck_o), .sck_oe_b_o(sck_oe_b_o),
        .sdi_i(sdi), .sdo_o(sdo_o), .sdo_oe_b_o(sdo_oe_b_o), .conv_start_o(conv_start_o),
        .conv_done_i(conv_done_i), .conv_value_i(conv_value_i), .conv_over_i(conv_over_i),
        .conv_under_i(conv_under_i), .chan_addr_o(chan_addr_o),
        .speed_code_o(speed_code_o), .mode_2x_o(mode_2x_o), .conv_busy_o(conv_busy_o)
    );
    acp_host_model host (
        .sdo_i(sdo_pin), .sck_i(sck_pin), .cs_b_o(cs_b), .sck_o(host_sck), .sdi_o(sdi)
    );

    task automatic test_done();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    function automatic logic [31:0] fw(input logic [29:0] v, input logic ov, input logic un);
        if (ov)
            return 32'h3000_0000;
        if (un)
            return 32'h0fff_ffff;
        return {2'b00, ~v[29], v[28:0]};
    endfunction : fw

    task automatic pulse_done(input logic [29:0] v, input logic ov, input logic un);
        @(negedge clk_sys_i);
        conv_done_i = 1'b1;
        conv_value_i = v;
        conv_over_i = ov;
        conv_under_i = un;
        @(negedge clk_sys_i);
        conv_done_i = 1'b0;
    endtask : pulse_done

    task automatic wait_start(input logic [4:0] ec, input logic [4:0] es);
        int k;
        for (k = 0; k < 200 && conv_start_o !== 1'b1; k++) @(negedge clk_sys_i);
        chk("start", conv_start_o, 1'b1);
        chk("chan", chan_addr_o, ec);
        chk("speed", speed_code_o, es);
        chk("mode", mode_2x_o, es[0]);
    endtask : wait_start

    // One whole conversion: flag check, result read, command, next start.
    task automatic cycle(input logic [29:0] v, input logic ov, input logic un,
                         input logic [12:0] cmd, input bit own, input logic [31:0] exp_w,
                         input logic [4:0] ec, input logic [4:0] es);
        int p;
        host.select(1'b0);
        repeat (6) @(negedge clk_sys_i);
        chk("busy_flag", sdo_pin, 1'b1);
        chk("busy", conv_busy_o, 1'b1);
        p = n_pulse;
        pulse_done(v, ov, un);
        chk("idle", conv_busy_o, 1'b0);
        host.frame(cmd, 32, own, got);
        chk("frame", got, exp_w);
        wait_start(ec, es);
        chk("end_flag", sdo_pin, 1'b1);
        host.select(1'b1);
        repeat (6) @(negedge clk_sys_i);
        chk("float", sdo_oe_b_o, 1'b1);
        chk("pulses", n_pulse - p, own ? 32 : 0);
    endtask : cycle

    initial
    begin
        clk_sys_i = 1'b0;
        forever #50 clk_sys_i = ~clk_sys_i;
    end

    initial
    begin
        #4_000_000;
        n_fail++;
        test_done();
    end

    initial
    begin
        rst_b_i = 1'b0;
        clk_src_strap_i = 1'b0;
        conv_done_i = 1'b0;
        conv_value_i = 30'h0;
        conv_over_i = 1'b0;
        conv_under_i = 1'b0;
        repeat (5) @(negedge clk_sys_i);
        chk("rst_speed", speed_code_o, 5'h08);
        chk("rst_float", sdo_oe_b_o, 1'b1);
        rst_b_i = 1'b1;
        wait_start(5'h00, 5'h08);
        chk("sck_dir", sck_oe_b_o, 1'b1);
        cycle(30'h0, 0, 0, 13'h16e3, 0, fw(30'h0, 0, 0), 5'h17, 5'h03);
        cycle(30'h3fff_ffff, 0, 0, 13'h14a0, 0, fw(30'h0, 0, 0), 5'h05, 5'h03);
        cycle(30'h0abc_def1, 0, 0, 13'h14a8, 0, fw(30'h3fff_ffff, 0, 0), 5'h05, 5'h08);
        cycle(30'h1555_5555, 1, 0, 13'h03ff, 0, 32'h3000_0000, 5'h05, 5'h08);
        clk_src_strap_i = 1'b1;
        repeat (6) @(negedge clk_sys_i);
        chk("sck_dir", sck_oe_b_o, 1'b0);
        cycle(30'h0abc_def1, 0, 1, 13'h12ab, 1, 32'h0fff_ffff, 5'h05, 5'h08);
        clk_src_strap_i = 1'b0;
        host.select(1'b0);
        repeat (6) @(negedge clk_sys_i);
        pulse_done(30'h0abc_def1, 0, 0);
        host.frame(13'h1423, 5, 1'b0, got);
        chk("abort_bits", got[4:0], 5'h05);
        host.select(1'b1);
        wait_start(5'h05, 5'h08);
        repeat (6) @(negedge clk_sys_i);
        chk("abort_float", sdo_oe_b_o, 1'b1);
        test_done();
    end
endmodule : acp_serial_port_bench

bind acp_serial_port acp_serial_port_props u_props (
    .clk_sys_i, .rst_b_i, .clk_src_strap_i, .cs_b_i, .sdo_o, .sdo_oe_b_o, .sck_oe_b_o,
    .conv_start_o, .conv_done_i, .chan_addr_o, .speed_code_o, .mode_2x_o, .conv_busy_o
);

// >>> bench/acp_serial_port_props.sv
// Concurrent checks on the pins of the converter serial port.
`timescale 1ns/1ps
module acp_serial_port_props
    import acp_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic clk_src_strap_i,
    input wire logic cs_b_i,
    input wire logic sdo_o,
    input wire logic sdo_oe_b_o,
    input wire logic sck_oe_b_o,
    input wire logic conv_start_o,
    input wire logic conv_done_i,
    input wire logic [CHAN_W-1:0] chan_addr_o,
    input wire logic [SPD_W-1:0] speed_code_o,
    input wire logic mode_2x_o,
    input wire logic conv_busy_o
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_b_i);

    // Select is synchronised, so the pins are given four samples to settle.
    sequence s_done_selected;
        conv_done_i && !cs_b_i && !sdo_oe_b_o;
    endsequence
    sequence s_select_held;
        (!cs_b_i)[*3];
    endsequence

    AST_DONE_FLAG_FALLS:
    assert property (s_done_selected ##1 s_select_held |=> !sdo_o)
        else $error("done flag did not fall after conversion end");
    AST_FLAG_HIGH_BUSY:
    assert property (conv_busy_o && !sdo_oe_b_o |-> sdo_o)
        else $error("done flag low while converting");
    AST_FLOAT_DESELECT:
    assert property (cs_b_i[*4] |=> sdo_oe_b_o)
        else $error("serial output driven while deselected");
    AST_DRIVE_SELECT:
    assert property ((!cs_b_i)[*4] |=> !sdo_oe_b_o)
        else $error("serial output floating while selected");
    AST_SCK_OWN:
    assert property (clk_src_strap_i[*5] |=> !sck_oe_b_o)
        else $error("serial clock not driven with strap high");
    AST_SCK_HOST:
    assert property ((!clk_src_strap_i)[*5] |=> sck_oe_b_o)
        else $error("serial clock driven with strap low");
    AST_START_FLAG_HIGH:
    assert property (conv_start_o |-> sdo_o)
        else $error("conversion start without high output");
    AST_START_ONCE:
    assert property (conv_start_o |=> !conv_start_o && conv_busy_o)
        else $error("start pulse not single or busy missing");
    AST_SETTINGS_HOLD:
    assert property (!conv_start_o |-> $stable(chan_addr_o) && $stable(speed_code_o))
        else $error("channel or speed changed without a start");
    AST_MODE_FROM_SPEED:
    assert property (mode_2x_o == speed_code_o[SPD_2X_BIT])
        else $error("mode flag disagrees with speed code");
endmodule : acp_serial_port_props

// >>> common/acp_pkg.sv
// Shared constants and types for the converter serial command port.
package acp_pkg;
    // System clock and the internally generated serial clock.
    localparam int CLK_PERIOD_NS = 100;
    localparam int SCK_HALF_NS = 400;
    localparam int SCK_HALF_CYC = SCK_HALF_NS / CLK_PERIOD_NS;
    localparam int SCK_DIV_W = 3;
    localparam logic [SCK_DIV_W-1:0] SCK_DIV_LAST = SCK_DIV_W'(SCK_HALF_CYC - 1);

    // Result frame layout.
    localparam int FRAME_W = 32;
    localparam int FRAME_MSB = 31;
    localparam int RESULT_W = 30;
    localparam int RESULT_SIGN = 29;
    localparam logic [1:0] FRAME_HEAD = 2'h0;
    localparam int BIT_CNT_W = 5;
    localparam logic [BIT_CNT_W-1:0] LAST_FALL = 5'h1f;
    localparam logic [RESULT_W-1:0] OVER_CODE = 30'h3000_0000;
    localparam logic [RESULT_W-1:0] UNDER_CODE = 30'h0fff_ffff;
    localparam int FIFO_DEPTH = 8;

    // Command word layout, first bit received lands in the top bit.
    localparam int CMD_W = 13;
    localparam int CMD_CNT_W = 4;
    localparam logic [CMD_CNT_W-1:0] CMD_LAST = 4'hc;
    localparam int PFX_MSB = 12;
    localparam int PFX_LSB = 10;
    localparam int CHAN_MSB = 9;
    localparam int CHAN_LSB = 5;
    localparam int SPD_MSB = 4;
    localparam int SPD_LSB = 0;
    localparam logic [2:0] PFX_UPDATE = 3'h5;
    localparam logic [2:0] PFX_KEEP_A = 3'h0;
    localparam logic [2:0] PFX_KEEP_B = 3'h4;

    // Channel address and speed fields.
    localparam int CHAN_W = 5;
    localparam int CHAN_SGL_BIT = 4;
    localparam int CHAN_A2_BIT = 2;
    localparam logic [CHAN_W-1:0] CHAN_RESET = 5'h00;
    localparam int SPD_W = 5;
    localparam int SPD_2X_BIT = 0;
    localparam logic [SPD_W-1:0] SPD_KEEP = 5'h00;
    localparam logic [SPD_W-1:0] SPD_RESET = 5'h08;

    typedef enum logic [2:0] {
        ST_CONV = 3'b001,
        ST_SLEEP = 3'b010,
        ST_DOUT = 3'b100
    } acp_state_t;
endpackage : acp_pkg

// >>> core/acp_result_fifo.sv
// Small result FIFO with a registered output stage.
`timescale 1ns/1ps
module acp_result_fifo #(
    parameter int WIDTH = 30,
    parameter int DEPTH = 8
) (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int PTR_W = $clog2(DEPTH);
    localparam int CNT_W = PTR_W + 1;
    localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);
    localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [PTR_W-1:0] wr_ptr_r;
    logic [PTR_W-1:0] rd_ptr_r;
    logic [CNT_W-1:0] count_r;
    logic push;
    logic pull;

    // The output register is refilled whenever it is empty or being taken.
    assign push = in_valid_i && (count_r != CNT_FULL);
    assign pull = (count_r != '0) && (!out_valid_o || out_ready_i);
    assign in_ready_o = (count_r != CNT_FULL);

    always_ff @(posedge clk_sys_i)
    begin
        if (push)
        begin
            mem_r[wr_ptr_r] <= in_data_i;
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_b_i)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_r <= (wr_ptr_r == PTR_LAST) ? '0 : wr_ptr_r + 1'b1;
            end
            if (pull)
            begin
                rd_ptr_r <= (rd_ptr_r == PTR_LAST) ? '0 : rd_ptr_r + 1'b1;
            end
            if (push && !pull)
            begin
                count_r <= count_r + 1'b1;
            end
            else if (pull && !push)
            begin
                count_r <= count_r - 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_b_i)
        begin
            out_valid_o <= 1'b0;
            out_data_o <= '0;
        end
        else if (pull)
        begin
            out_valid_o <= 1'b1;
            out_data_o <= mem_r[rd_ptr_r];
        end
        else if (out_ready_i)
        begin
            out_valid_o <= 1'b0;
        end
    end
endmodule : acp_result_fifo

// >>> core/acp_serial_port.sv
// Serial status, result and command port of a multichannel converter.
//
// How it works
// - Output bits change on serial clock falling edge.
// - Strap low takes host clock, high drives it.
// - Data output shows latest result, MSB first.
// - Chip select high floats the serial output.
// - Output shows done flag while converting or asleep.
// - First rising clock with select low starts output.
// - Select rising during output aborts and restarts.
// - Command word captured during the output cycle.
// - First conversion: channels zero/one, default speed, 1X.
// - Every conversion ends in the sleep state.
// - Prefix 101 updates; 000 or 100 keeps settings.
// - Five bits after update prefix set channel.
// - Next five set speed; all zero keeps it.
// - 2X mode delivers results one conversion late.
// - First address bit picks single or differential.
// - Eight-channel variant forces top index bit zero.
// - Frame opens with zero bits, then sign, magnitude.
// - Over and underrange use fixed clamp codes.
// - Frame is 32 bits long.
// - 32nd falling edge drives high and restarts.
`timescale 1ns/1ps
module acp_serial_port
    import acp_pkg::*;
#(
    parameter bit SIXTEEN_CH = 1'b1
) (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic clk_src_strap_i,
    input wire logic cs_b_i,
    input wire logic sck_i,
    output logic sck_o,
    output logic sck_oe_b_o,
    input wire logic sdi_i,
    output logic sdo_o,
    output logic sdo_oe_b_o,
    output logic conv_start_o,
    input wire logic conv_done_i,
    input wire logic [RESULT_W-1:0] conv_value_i,
    input wire logic conv_over_i,
    input wire logic conv_under_i,
    output logic [CHAN_W-1:0] chan_addr_o,
    output logic [SPD_W-1:0] speed_code_o,
    output logic mode_2x_o,
    output logic conv_busy_o
);
    logic cs_s1_r;
    logic cs_s2_r;
    logic cs_s3_r;
    logic sck_s1_r;
    logic sck_s2_r;
    logic sck_s3_r;
    logic sdi_s1_r;
    logic sdi_s2_r;
    logic strap_s1_r;
    logic strap_s2_r;

    acp_state_t state_r;
    acp_state_t state_nxt;
    logic [FRAME_W-1:0] shift_r;
    logic [FRAME_W-1:0] shift_nxt;
    logic [BIT_CNT_W-1:0] bit_cnt_r;
    logic [CMD_W-1:0] cmd_r;
    logic [CMD_CNT_W-1:0] cmd_cnt_r;
    logic cmd_full_r;
    logic [CHAN_W-1:0] chan_pend_r;
    logic [SPD_W-1:0] spd_pend_r;
    logic start_pend_r;
    logic [RESULT_W-1:0] prev_word_r;
    logic [RESULT_W-1:0] conv_word;
    logic [RESULT_W-1:0] push_word;

    logic run_r;
    logic [SCK_DIV_W-1:0] div_r;
    logic int_rise_r;
    logic int_fall_r;

    logic int_mode;
    logic rise_ev;
    logic fall_ev;
    logic cs_rise;
    logic enter_dout;
    logic frame_end;
    logic leave_dout;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [RESULT_W-1:0] fifo_out_data;

    // Pins are asynchronous to the system clock; second stages are read, and third stages only for clock and select edge detection.
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_b_i)
        begin
            cs_s1_r <= 1'b1;
            cs_s2_r <= 1'b1;
            cs_s3_r <= 1'b1;
            sck_s1_r <= 1'b0;
            sck_s2_r <= 1'b0;
            sck_s3_r <= 1'b0;
            sdi_s1_r <= 1'b0;
            sdi_s2_r <= 1'b0;
            strap_s1_r <= 1'b0;
            strap_s2_r <= 1'b0;
        end
        else
        begin
            cs_s1_r <= cs_b_i;
            cs_s2_r <= cs_s1_r;
            cs_s3_r <= cs_s2_r;
            sck_s1_r <= sck_i;
            sck_s2_r <= sck_s1_r;
            sck_s3_r <= sck_s2_r;
            sdi_s1_r <= sdi_i;
            sdi_s2_r <= sdi_s1_r;
            strap_s1_r <= clk_src_strap_i;
            strap_s2_r <= strap_s1_r;
        end
    end

    assign int_mode = strap_s2_r;
    assign rise_ev = int_mode ? int_rise_r : (sck_s2_r && !sck_s3_r);
    assign fall_ev = int_mode ? int_fall_r : (!sck_s2_r && sck_s3_r);
    assign cs_rise = cs_s2_r && !cs_s3_r;
    assign enter_dout = (state_r == ST_SLEEP) && rise_ev && !cs_s2_r;
    assign frame_end = (state_r == ST_DOUT) && fall_ev && (bit_cnt_r == LAST_FALL);
    assign leave_dout = ((state_r == ST_DOUT) && cs_rise) || frame_end;

    // Over and underrange clamp; otherwise the sign bit is inverted two's complement.
    always_comb
    begin
        if (conv_over_i)
        begin
            conv_word = OVER_CODE;
        end
        else if (conv_under_i)
        begin
            conv_word = UNDER_CODE;
        end
        else
        begin
            conv_word = {~conv_value_i[RESULT_SIGN], conv_value_i[RESULT_SIGN-1:0]};
        end
    end

    // In 2X mode the frame carries the previous conversion's result.
    assign push_word = mode_2x_o ? prev_word_r : conv_word;

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_b_i)
        begin
            prev_word_r <= '0;
        end
        else if (conv_done_i)
        begin
            prev_word_r <= conv_word;
        end
    end

    acp_result_fifo #(
        .WIDTH(RESULT_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_sys_i(clk_sys_i),
        .rst_b_i(rst_b_i),
        .in_valid_i(conv_done_i),
        .in_ready_o(fifo_in_ready),
        .in_data_i(push_word),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(enter_dout),
        .out_data_o(fifo_out_data)
    );

    always_comb
    begin
        state_nxt = state_r;
        shift_nxt = shift_r;
        case (state_r)
            ST_CONV:
            begin
                if (fifo_out_valid && !start_pend_r)
                begin
                    state_nxt = ST_SLEEP;
                end
            end
            ST_SLEEP:
            begin
                if (enter_dout)
                begin
                    state_nxt = ST_DOUT;
                    shift_nxt = {FRAME_HEAD, fifo_out_data};
                end
            end
            ST_DOUT:
            begin
                if (leave_dout)
                begin
                    state_nxt = ST_CONV;
                end
                else if (fall_ev)
                begin
                    shift_nxt = {shift_r[FRAME_W-2:0], 1'b0};
                end
            end
            default:
            begin
                state_nxt = ST_CONV;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_b_i)
        begin
            state_r <= ST_CONV;
            shift_r <= '0;
        end
        else
        begin
            state_r <= state_nxt;
            shift_r <= shift_nxt;
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_b_i)
        begin
            bit_cnt_r <= '0;
        end
        else if (enter_dout)
        begin
            bit_cnt_r <= '0;
        end
        else if ((state_r == ST_DOUT) && fall_ev)
        begin
            bit_cnt_r <= bit_cnt_r + 1'b1;
        end
    end

    // The done flag is high while converting, low asleep, then frame bits follow.
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_b_i)
        begin
            sdo_o <= 1'b1;
            sdo_oe_b_o <= 1'b1;
        end
        else
        begin
            sdo_oe_b_o <= cs_s2_r;
            case (state_nxt)
                ST_DOUT: sdo_o <= shift_nxt[FRAME_MSB];
                ST_SLEEP: sdo_o <= 1'b0;
                default: sdo_o <= 1'b1;
            endcase
        end
    end

    // Command bits are sampled on rising edges, the entering edge included.
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_b_i)
        begin
            cmd_r <= '0;
            cmd_cnt_r <= '0;
            cmd_full_r <= 1'b0;
        end
        else
        begin
            cmd_full_r <= 1'b0;
            if (enter_dout)
            begin
                cmd_r <= {cmd_r[CMD_W-2:0], sdi_s2_r};
                cmd_cnt_r <= CMD_CNT_W'(1);
            end
            else if ((state_r == ST_DOUT) && rise_ev && (cmd_cnt_r <= CMD_LAST))
            begin
                cmd_r <= {cmd_r[CMD_W-2:0], sdi_s2_r};
                cmd_cnt_r <= cmd_cnt_r + 1'b1;
                cmd_full_r <= (cmd_cnt_r == CMD_LAST);
            end
        end
    end

    // Settings wait here and reach the outputs when the next conversion starts.
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_b_i)
        begin
            chan_pend_r <= CHAN_RESET;
            spd_pend_r <= SPD_RESET;
        end
        else if (cmd_full_r)
        begin
            // Unlisted prefixes are treated like the keep codes.
            if (cmd_r[PFX_MSB:PFX_LSB] == PFX_UPDATE)
            begin
                chan_pend_r <= cmd_r[CHAN_MSB:CHAN_LSB];
                if (!SIXTEEN_CH)
                begin
                    chan_pend_r[CHAN_A2_BIT] <= 1'b0;
                end
                if (cmd_r[SPD_MSB:SPD_LSB] != SPD_KEEP)
                begin
                    spd_pend_r <= cmd_r[SPD_MSB:SPD_LSB];
                end
            end
        end
    end

    // A start waits for room in the result buffer, so results are never dropped.
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_b_i)
        begin
            start_pend_r <= 1'b1;
            conv_start_o <= 1'b0;
            conv_busy_o <= 1'b0;
            chan_addr_o <= CHAN_RESET;
            speed_code_o <= SPD_RESET;
            mode_2x_o <= 1'b0;
        end
        else
        begin
            conv_start_o <= 1'b0;
            // Cleared first so that a start in the same cycle keeps busy high.
            if (conv_done_i)
            begin
                conv_busy_o <= 1'b0;
            end
            if (leave_dout)
            begin
                start_pend_r <= 1'b1;
            end
            else if (start_pend_r && fifo_in_ready)
            begin
                start_pend_r <= 1'b0;
                conv_start_o <= 1'b1;
                conv_busy_o <= 1'b1;
                chan_addr_o <= chan_pend_r;
                speed_code_o <= spd_pend_r;
                mode_2x_o <= spd_pend_r[SPD_2X_BIT];
            end
        end
    end

    // Internal clock runs only while asleep or shifting with select low.
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_b_i)
        begin
            run_r <= 1'b0;
        end
        else if (!int_mode || cs_s2_r || (state_r == ST_CONV) || frame_end)
        begin
            run_r <= 1'b0;
        end
        else if (state_r == ST_SLEEP)
        begin
            run_r <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_b_i)
        begin
            div_r <= '0;
            sck_o <= 1'b0;
            int_rise_r <= 1'b0;
            int_fall_r <= 1'b0;
        end
        else
        begin
            int_rise_r <= 1'b0;
            int_fall_r <= 1'b0;
            if (!run_r)
            begin
                div_r <= '0;
                sck_o <= 1'b0;
                int_fall_r <= sck_o;
            end
            else if (div_r == SCK_DIV_LAST)
            begin
                div_r <= '0;
                sck_o <= !sck_o;
                int_rise_r <= !sck_o;
                int_fall_r <= sck_o;
            end
            else
            begin
                div_r <= div_r + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_b_i)
        begin
            sck_oe_b_o <= 1'b1;
        end
        else
        begin
            sck_oe_b_o <= !strap_s2_r;
        end
    end
endmodule : acp_serial_port
